//--- logic/wdtew_pkg.sv
// Package: register map, field positions and reset values of the early-window watchdog
package wdtew_pkg;

  // ***************************************************************
  // Register offsets (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_FEED       = 8'h04;
  localparam logic [7:0] OFS_COUNT      = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // ***************************************************************
  // Control field positions
  // ***************************************************************
  localparam int POS_RST_EARLY     = 30;
  localparam int POS_WIN_EN        = 29;
  localparam int POS_RST_EARLY_LSB = 20;
  localparam int POS_INT_EARLY_LSB = 16;
  localparam int POS_INT_EARLY     = 12;
  localparam int POS_WDT_RST_EN    = 11;
  localparam int POS_WDT_INT_EN    = 10;
  localparam int POS_EN            = 8;
  localparam int SEL_WIDTH         = 4;

  // ***************************************************************
  // Event status bits, feed keys, reset values, tick period
  // ***************************************************************
  localparam int EVT_INT_EARLY = 0;
  localparam int EVT_RST_EARLY = 1;
  localparam int EVT_WIDTH     = 2;
  localparam logic [7:0] FEED_KEY_FIRST  = 8'ha5;
  localparam logic [7:0] FEED_KEY_SECOND = 8'h5a;
  localparam logic [3:0] RESET_SEL       = 4'h0;
  localparam logic       RESET_BIT       = 1'b0;
  localparam int unsigned TICK_DIV_RESET = 1;

endpackage : wdtew_pkg

//--- logic/wdtew_top.sv
// Early-window part of a windowed watchdog with APB register access
// Overview of operation
// - Reset-early selector bits 23:20, code n gives threshold 2^(31-n) ticks.
// - Interrupt-early selector bits 19:16 uses the same power-of-two mapping.
// - Early-feed flag bit 12 sets when a feed completes before interrupt threshold.
// - Early-feed flag reads one after an event, resets zero, software writable.
// - Watchdog interrupt from early flag only while interrupt enable bit is one.
// - With window mode and interrupt enable on, early interrupt events raise the watchdog interrupt.
// - Reset enable lets early reset events in window mode produce a response.
// - Early-reset flag sets on early reset event regardless of window or enable.
`timescale 1ns/1ps
`default_nettype none

module wdtew_top #(
  parameter int unsigned TICK_DIV = wdtew_pkg::TICK_DIV_RESET
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  output logic             o_wdt_rst
);

  // ***************************************************************
  // Elaboration checks and helpers
  // ***************************************************************
  if (TICK_DIV < 1 || TICK_DIV > 65535)
  begin : g_bad_div
    $error("TICK_DIV must lie between 1 and 65535");
  end

  // Threshold in ticks for a selector code
  function automatic logic [31:0] sel_to_ticks(input logic [3:0] code);
    logic [4:0] shift;
    shift = 5'd31 - {1'b0, code};
    return 32'h1 << shift;
  endfunction : sel_to_ticks

  // ***************************************************************
  // State
  // ***************************************************************
  logic        rst_early;
  logic        win_en;
  logic [3:0]  rst_early_sel;
  logic [3:0]  int_early_sel;
  logic        int_early;
  logic        wdt_rst_en;
  logic        wdt_int_en;
  logic        en;
  logic        feed_armed;
  logic [31:0] count;
  logic [15:0] div_cnt;
  logic [1:0]  irq_status;
  logic [1:0]  irq_enable;

  // ***************************************************************
  // APB decode
  // ***************************************************************
  wire         access    = i_psel & i_penable;
  wire         done      = access & o_pready;
  wire         wr        = done & i_pwrite;
  wire         hit_ctrl  = (i_paddr == wdtew_pkg::OFS_CONTROL);
  wire         hit_feed  = (i_paddr == wdtew_pkg::OFS_FEED);
  wire         hit_cnt   = (i_paddr == wdtew_pkg::OFS_COUNT);
  wire         hit_stat  = (i_paddr == wdtew_pkg::OFS_IRQ_STATUS);
  wire         hit_clr   = (i_paddr == wdtew_pkg::OFS_IRQ_CLEAR);
  wire         hit_ien   = (i_paddr == wdtew_pkg::OFS_IRQ_ENABLE);
  wire         mapped    = hit_ctrl | hit_feed | hit_cnt | hit_stat | hit_clr | hit_ien;
  wire         wr_ctrl   = wr & hit_ctrl;
  wire         wr_feed   = wr & hit_feed;
  wire         wr_clr    = wr & hit_clr;
  wire         wr_ien    = wr & hit_ien;
  wire [7:0]   feed_key  = i_pwdata[7:0];

  // Control word as seen by software; unused bits read zero
  wire [31:0] ctrl_word =
    ({31'h0, rst_early}  << wdtew_pkg::POS_RST_EARLY) |
    ({31'h0, win_en}     << wdtew_pkg::POS_WIN_EN) |
    ({28'h0, rst_early_sel} << wdtew_pkg::POS_RST_EARLY_LSB) |
    ({28'h0, int_early_sel} << wdtew_pkg::POS_INT_EARLY_LSB) |
    ({31'h0, int_early}  << wdtew_pkg::POS_INT_EARLY) |
    ({31'h0, wdt_rst_en} << wdtew_pkg::POS_WDT_RST_EN) |
    ({31'h0, wdt_int_en} << wdtew_pkg::POS_WDT_INT_EN) |
    ({31'h0, en}         << wdtew_pkg::POS_EN);

  // Read mux; feed and clear registers are write-only
  wire [31:0] rd_word =
    hit_ctrl ? ctrl_word :
    hit_cnt  ? count :
    hit_stat ? {30'h0, irq_status} :
    hit_ien  ? {30'h0, irq_enable} : 32'h0;

  // ***************************************************************
  // Tick divider and feed detection
  // ***************************************************************
  wire tick      = en & (div_cnt == 16'(TICK_DIV - 1));
  wire feed_done = wr_feed & feed_armed & (feed_key == wdtew_pkg::FEED_KEY_SECOND);

  // Early events: compare the running count at the completed feed
  wire [31:0] int_thr    = sel_to_ticks(int_early_sel);
  wire [31:0] rst_thr    = sel_to_ticks(rst_early_sel);
  wire        ev_int     = feed_done & (count < int_thr);
  wire        ev_rst     = feed_done & (count < rst_thr);
  wire [1:0]  events     = {ev_rst, ev_int};

  // Next values of the software-writable flags: an event wins over a write
  wire next_int_early = ev_int |
    (wr_ctrl ? i_pwdata[wdtew_pkg::POS_INT_EARLY] : int_early);
  wire next_rst_early = ev_rst |
    (wr_ctrl ? i_pwdata[wdtew_pkg::POS_RST_EARLY] : rst_early);

  // Sticky status: set beats a simultaneous clear
  wire [1:0] next_irq_status = events | (irq_status & ~(wr_clr ? i_pwdata[1:0] : 2'b00));

  // Interrupt: early flag only with window mode and interrupt enable, plus status path
  wire early_irq = int_early & wdt_int_en & win_en;
  wire next_irq  = early_irq | (|(irq_status & irq_enable));
  wire next_rst  = ev_rst & win_en & wdt_rst_en;

  // ***************************************************************
  // APB response: one wait state, data and error registered
  // ***************************************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= access & ~o_pready;
      o_prdata  <= (access & ~o_pready & ~i_pwrite) ? rd_word : 32'h0;
      o_pslverr <= access & ~o_pready & ~mapped;
    end
  end

  // ***************************************************************
  // Control register
  // ***************************************************************
  // Selectors are taken as written; software keeps the watchdog off first
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      win_en        <= wdtew_pkg::RESET_BIT;
      rst_early_sel <= wdtew_pkg::RESET_SEL;
      int_early_sel <= wdtew_pkg::RESET_SEL;
      wdt_rst_en    <= wdtew_pkg::RESET_BIT;
      wdt_int_en    <= wdtew_pkg::RESET_BIT;
      en            <= wdtew_pkg::RESET_BIT;
    end
    else if (wr_ctrl)
    begin
      win_en        <= i_pwdata[wdtew_pkg::POS_WIN_EN];
      rst_early_sel <= i_pwdata[wdtew_pkg::POS_RST_EARLY_LSB +: wdtew_pkg::SEL_WIDTH];
      int_early_sel <= i_pwdata[wdtew_pkg::POS_INT_EARLY_LSB +: wdtew_pkg::SEL_WIDTH];
      wdt_rst_en    <= i_pwdata[wdtew_pkg::POS_WDT_RST_EN];
      wdt_int_en    <= i_pwdata[wdtew_pkg::POS_WDT_INT_EN];
      en            <= i_pwdata[wdtew_pkg::POS_EN];
    end
  end

  // Event flags and sticky status
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      int_early  <= wdtew_pkg::RESET_BIT;
      rst_early  <= wdtew_pkg::RESET_BIT;
      irq_status <= 2'b00;
      irq_enable <= 2'b00;
    end
    else
    begin
      int_early  <= next_int_early;
      rst_early  <= next_rst_early;
      irq_status <= next_irq_status;
      if (wr_ien)
      begin
        irq_enable <= i_pwdata[1:0];
      end
    end
  end

  // ***************************************************************
  // Feed sequence, tick divider, counter
  // ***************************************************************
  // Any write to the feed register other than the first key disarms
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      feed_armed <= 1'b0;
    end
    else if (wr_feed)
    begin
      feed_armed <= (feed_key == wdtew_pkg::FEED_KEY_FIRST);
    end
  end

  // Divider held at zero while disabled so the first tick is a full period
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      div_cnt <= 16'h0;
    end
    else if (!en || tick)
    begin
      div_cnt <= 16'h0;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h1;
    end
  end

  // Count saturates rather than wrapping, so a stale feed never looks early
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      count <= 32'h0;
    end
    else if (feed_done)
    begin
      count <= 32'h0;
    end
    else if (tick && count != 32'hffff_ffff)
    begin
      count <= count + 32'h1;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_irq     <= 1'b0;
      o_wdt_rst <= 1'b0;
    end
    else
    begin
      o_irq     <= next_irq;
      o_wdt_rst <= next_rst;
    end
  end

endmodule : wdtew_top

`default_nettype wire

//--- tb/wdtew_sva.sv
// Checker: port-level timing properties of the early-window watchdog
`timescale 1ns/1ps
`default_nettype none
module wdtew_sva (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_irq,
  input wire logic        o_wdt_rst
);
  // Completed write, and completed second feed key
  wire wr_done = o_pready && i_pwrite;
  wire feed_done = wr_done && i_paddr == wdtew_pkg::OFS_FEED
    && i_pwdata[7:0] == wdtew_pkg::FEED_KEY_SECOND;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  // ***********************************
  // Properties
  // ***********************************
  property p_rdy; i_psel && i_penable && !o_pready |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not after one wait");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; o_pready |->
    o_pslverr == !(i_paddr inside {8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18}); endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_rd0; !o_pready |-> o_prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside access");
  property p_rst1; o_wdt_rst |=> !o_wdt_rst; endproperty
  a_rst1: assert property (p_rst1) else $error("reset pulse too long");
  property p_rstc; o_wdt_rst |-> $past(feed_done) || $past(feed_done, 2); endproperty
  a_rstc: assert property (p_rstc) else $error("reset pulse without feed");
  property p_irqr; $rose(o_irq) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3); endproperty
  a_irqr: assert property (p_irqr) else $error("irq rose without write");
  property p_irqf; $fell(o_irq) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3); endproperty
  a_irqf: assert property (p_irqf) else $error("irq fell without write");
endmodule : wdtew_sva
bind wdtew_top wdtew_sva i_wdtew_sva (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_irq(o_irq), .o_wdt_rst(o_wdt_rst));
`default_nettype wire

//--- tb/tb_top.sv
// Testbench: APB scenarios for the early-window watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Bench signals, all inputs set at time zero
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, q;
  logic        rdy, err, irq, wrst, qe;
  int          err_total = 0;
  int          checked = 0;
  int          rst_seen = 0;
  always #2 clk = ~clk;
  // Reset pulses stand one cycle, so count them as they pass
  always @(posedge clk) if (wrst === 1'b1) rst_seen <= rst_seen + 1;
  wdtew_top i_wdtew_top (.i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(err), .o_irq(irq), .o_wdt_rst(wrst));
  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // One APB transfer; ready, data and error taken at the edge that samples ready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 16);
    cmp("pready", 32'h1, {31'h0, rdy});
    if (rdy !== 1'b1)
      conclude();
    q = prd;
    qe = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    cmp(n, e, q);
  endtask : rd
  task automatic feed;
    apb(1'b1, 8'h04, {24'h0, wdtew_pkg::FEED_KEY_FIRST});
    apb(1'b1, 8'h04, {24'h0, wdtew_pkg::FEED_KEY_SECOND});
  endtask : feed
  // Interrupt lags the write by a registered stage
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1;
    cmp("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_is
  // ***********************************
  // Scenarios
  // ***********************************
  task automatic t_map;
    rd(8'h00, 32'h0, "control reset");
    rd(8'h08, 32'h0, "unmapped read");
    cmp("unmapped error", 32'h1, {31'h0, qe});
  endtask : t_map
  // Every selector code; count is idle so each feed is early
  task automatic t_codes;
    logic [31:0] c;
    for (int k = 0; k < 16; k++)
    begin
      c = 32'h2000_0c00 | (32'(k) << 20) | (32'(k) << 16);
      apb(1'b1, 8'h00, c);
      feed();
      rd(8'h00, c | 32'h4000_1000, "control flags");
      irq_is(1'b1);
      cmp("reset pulses", 32'(k + 1), 32'(rst_seen));
    end
  endtask : t_codes
  task automatic t_gate;
    apb(1'b1, 8'h00, 32'h20ff_0000);
    feed();
    irq_is(1'b0);
    cmp("reset pulses", 32'd16, 32'(rst_seen));
    rd(8'h00, 32'h60ff_1000, "flags gated");
    apb(1'b1, 8'h00, 32'h60ff_1400);
    irq_is(1'b1);
    apb(1'b1, 8'h00, 32'h20ff_0400);
    irq_is(1'b0);
    rd(8'h10, 32'h3, "status");
    apb(1'b1, 8'h18, 32'h1);
    irq_is(1'b1);
    rd(8'h18, 32'h1, "irq enable");
    apb(1'b1, 8'h14, 32'h1);
    rd(8'h10, 32'h2, "status cleared");
    irq_is(1'b0);
    apb(1'b1, 8'h18, 32'h0);
  endtask : t_gate
  // Window off: flags still set, but no interrupt and no reset pulse
  task automatic t_nowin;
    apb(1'b1, 8'h00, 32'h00ff_0c00);
    feed();
    irq_is(1'b0);
    cmp("reset pulses", 32'd16, 32'(rst_seen));
    rd(8'h00, 32'h40ff_1c00, "flags without window");
  endtask : t_nowin
  // Feed between 2^16 and 2^17: interrupt-early (code f) quiet, reset-early (code e) flags
  task automatic t_late;
    apb(1'b1, 8'h00, 32'h20ef_0c00);
    apb(1'b1, 8'h00, 32'h20ef_0d00);
    feed();
    apb(1'b1, 8'h00, 32'h20ef_0d00);
    repeat (65540) @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    cmp("count at limit", 32'h1, {31'h0, q >= 32'h1_0000});
    feed();
    rd(8'h00, 32'h60ef_0d00, "late feed");
    cmp("reset pulses", 32'd18, 32'(rst_seen));
    apb(1'b0, 8'h0c, 32'h0);
    cmp("count restart", 32'h1, {31'h0, q < 32'h10});
  endtask : t_late
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_map();
    t_codes();
    t_gate();
    t_nowin();
    t_late();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
